//--- inc/motor_pwm_pkg.sv
package motor_pwm_pkg;
	// byte offsets of the register words
	localparam logic [5:0] A_CTRL0  = 6'h00;
	localparam logic [5:0] A_CTRL1  = 6'h04;
	localparam logic [5:0] A_PBUF   = 6'h08;
	localparam logic [5:0] A_DUTY_U = 6'h0C;
	localparam logic [5:0] A_DUTY_V = 6'h10;
	localparam logic [5:0] A_DUTY_W = 6'h14;
	localparam logic [5:0] A_DTR    = 6'h18;
	localparam logic [5:0] A_SBUF   = 6'h1C;
	localparam logic [5:0] A_LBUF   = 6'h20;
	localparam logic [5:0] A_POL    = 6'h24;
	localparam logic [5:0] A_IRQ    = 6'h28;
	localparam logic [5:0] A_LDSW   = 6'h2C;
	localparam logic [5:0] A_COUNT  = 6'h30;
	localparam logic [5:0] A_PACT   = 6'h34;
	// control 0 fields
	localparam int C0_MODE   = 0;
	localparam int C0_LDM    = 2;
	localparam int C0_LDU    = 3;
	localparam int C0_SRC    = 4;
	localparam int C0_OEN    = 5;
	localparam int C0_KEN    = 6;
	// control 1 fields
	localparam int C1_CKS    = 0;
	localparam int C1_UPDN   = 2;
	localparam int C1_RUN    = 3;
	localparam int C1_DIR    = 4;
	localparam int C1_DTS    = 5;
	// interrupt control fields
	localparam int IQ_UDF    = 0;
	localparam int IQ_MAT    = 1;
	localparam int IQ_UDE    = 2;
	localparam int IQ_MAE    = 3;
	// load switch fields
	localparam int LS_PAT    = 3;
	// reset values, fixed read values and the mode encoding
	localparam logic [6:0] CTRL0_RST = 7'h00;
	localparam logic [6:0] CTRL1_RST = 7'h00;
	localparam logic [3:0] IRQ_RST   = 4'h0;
	localparam logic [5:0] POL_RST   = 6'h00;
	localparam logic [7:0] DTR_RST   = 8'h00;
	localparam logic [7:0] LDSW_READ = 8'hF0;
	localparam logic [3:0] FILL_ONES = 4'hF;
	typedef enum logic [1:0] {
		MODE_AC_DT  = 2'b00,
		MODE_BLDC   = 2'b01,
		MODE_BLDC_DT = 2'b10,
		MODE_SPARE  = 2'b11
	} mode_type;
endpackage

//--- verification/bridge_model.sv
`timescale 1ns/1ps
module bridge_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// gate drives and their active levels
	input  wire logic [5:0]  pins,
	input  wire logic [5:0]  pol,
	// counts of shorts and of u leg on cycles
	output logic      [15:0] shoot_cnt,
	output logic      [15:0] on_cnt
);
	logic [5:0] on_w;
	logic [5:0] on_q;
	logic       hit;
	// a transistor conducts while its pin sits at its active level
	assign on_w = ~(pins ^ pol);
	// a leg turning on while its partner is on, or was on a cycle ago, shorts the supply
	always_comb begin
		hit = 1'b0;
		for (int p = 0; p < 3; p++) begin
			if (on_w[2*p] && (on_w[2*p+1] || on_q[2*p+1]))
				hit = 1'b1;
			if (on_w[2*p+1] && (on_w[2*p] || on_q[2*p]))
				hit = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			shoot_cnt <= 16'h0000;
			on_cnt    <= 16'h0000;
			on_q      <= 6'h00;
		end else begin
			on_q <= on_w;
			if (hit) begin
				shoot_cnt <= shoot_cnt + 16'h0001;
			end
			if (on_w[0]) begin
				on_cnt <= on_cnt + 16'h0001;
			end
		end
	end
endmodule

//--- verification/three_phase_motor_pwm_bench.sv
`timescale 1ns/1ps
module three_phase_motor_pwm_bench;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [5:0]  addr = 6'h00;
	logic        rd_en = 1'b0;
	logic        wr_en = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic        waitreq;
	logic        cmatch = 1'b0;
	logic        kill = 1'b0;
	logic [5:0]  pins;
	logic        udf_req;
	logic        mat_req;
	logic [15:0] shoot;
	logic [15:0] ons;
	logic [31:0] rv;
	int          num_errors = 0;
	int          n_tests = 0;
	int          cyc = 0;

	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	three_phase_motor_pwm #(.CW(16)) three_phase_motor_pwm_inst (
		.CLK_SYS(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
		.COMPARE_MATCH(cmatch), .OUTPUT_KILL_PIN(kill),
		.PHASE_U_POS(pins[0]), .PHASE_U_NEG(pins[1]), .PHASE_V_POS(pins[2]),
		.PHASE_V_NEG(pins[3]), .PHASE_W_POS(pins[4]), .PHASE_W_NEG(pins[5]),
		.UNDERFLOW_REQ(udf_req), .MATCH_REQ(mat_req));

	bridge_model bridge_model_inst (.clk(clk), .rstn(rstn), .pins(pins), .pol(6'h3F),
		.shoot_cnt(shoot), .on_cnt(ons));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// request stands until waitrequest is sampled low at a rising edge; data taken at that edge
	task automatic bus(input logic rw, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		rd_en <= ~rw;
		wr_en <= rw;
		do begin
			@(posedge clk);
		end while (waitreq !== 1'b0);
		rv = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [5:0] a);
		bus(1'b0, a, 32'h00000000);
	endtask

	task automatic pulse(input logic sel);
		for (int i = 0; i < 300; i++) begin
			@(negedge clk);
			if ((sel ? mat_req : udf_req) === 1'b1) break;
		end
	endtask

	// spacing between two event pulses in clock cycles
	task automatic span(input logic sel, input int exp);
		int t0;
		pulse(sel);
		t0 = cyc;
		pulse(sel);
		chk(32'(cyc - t0), 32'(exp));
	endtask

	task automatic close_out;
		$display("counts: %0d compares, %0d mismatches", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// whole run needs under a thousand cycles
	initial begin
		#200000;
		num_errors++;
		close_out();
	end

	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rd(motor_pwm_pkg::A_CTRL0); chk(rv[7:0], 8'h80);
		rd(motor_pwm_pkg::A_CTRL1); chk(rv[7:0], 8'h90);
		rd(motor_pwm_pkg::A_IRQ); chk(rv[7:0], 8'hF0);
		rd(6'h3C); chk(rv, 32'h00000000);
		chk(pins, 6'h3F);
		$display("test reset done");
		wr(motor_pwm_pkg::A_PBUF, 32'h00000004);
		rd(motor_pwm_pkg::A_PACT); chk(rv[15:0], 16'h0004);
		wr(motor_pwm_pkg::A_IRQ, 32'h0000000C);
		wr(motor_pwm_pkg::A_CTRL1, 32'h00000008);
		span(1'b1, 5);
		wr(motor_pwm_pkg::A_CTRL1, 32'h00000009);
		span(1'b1, 10);
		wr(motor_pwm_pkg::A_CTRL1, 32'h00000000);
		rd(motor_pwm_pkg::A_IRQ); chk(rv[7:0], 8'hFE);
		wr(motor_pwm_pkg::A_IRQ, 32'h0000000C);
		rd(motor_pwm_pkg::A_IRQ); chk(rv[7:0], 8'hFC);
		wr(motor_pwm_pkg::A_CTRL1, 32'h0000000C);
		span(1'b0, 9);
		wr(motor_pwm_pkg::A_CTRL1, 32'h00000000);
		wr(motor_pwm_pkg::A_PBUF, 32'h00000000);
		rd(motor_pwm_pkg::A_PACT); chk(rv[15:0], 16'h0000);
		wr(motor_pwm_pkg::A_CTRL1, 32'h00000008);
		repeat (20) @(posedge clk);
		rd(motor_pwm_pkg::A_COUNT); chk(rv[15:0], 16'h0000);
		wr(motor_pwm_pkg::A_CTRL1, 32'h00000000);
		$display("test counting done");
		wr(motor_pwm_pkg::A_POL, 32'h0000003F);
		wr(motor_pwm_pkg::A_PBUF, 32'h0000000F);
		wr(motor_pwm_pkg::A_DUTY_U, 32'h00000008);
		wr(motor_pwm_pkg::A_DUTY_V, 32'h00000004);
		wr(motor_pwm_pkg::A_DUTY_W, 32'h0000000C);
		wr(motor_pwm_pkg::A_DTR, 32'h00000002);
		wr(motor_pwm_pkg::A_CTRL0, 32'h00000020);
		wr(motor_pwm_pkg::A_CTRL1, 32'h00000008);
		// counts before now include the reset polarity, so look at growth only
		rv = {shoot, ons};
		repeat (200) @(posedge clk);
		chk(shoot, rv[31:16]);
		chk(ons != rv[15:0], 1'b1);
		wr(motor_pwm_pkg::A_CTRL1, 32'h00000000);
		$display("test dead time done");
		wr(motor_pwm_pkg::A_SBUF, 32'h0000003F);
		wr(motor_pwm_pkg::A_LBUF, 32'h0000002A);
		wr(motor_pwm_pkg::A_CTRL0, 32'h00000021);
		repeat (8) @(posedge clk);
		chk(pins, 6'h2A);
		wr(motor_pwm_pkg::A_CTRL0, 32'h00000061);
		kill <= 1'b1;
		repeat (8) @(posedge clk);
		chk(pins, 6'h00);
		kill <= 1'b0;
		repeat (8) @(posedge clk);
		chk(pins, 6'h2A);
		wr(motor_pwm_pkg::A_CTRL0, 32'h00000001);
		repeat (4) @(posedge clk);
		chk(pins, 6'h00);
		wr(motor_pwm_pkg::A_POL, 32'h00000000);
		repeat (4) @(posedge clk);
		chk(pins, 6'h3F);
		$display("test levels done");
		wr(motor_pwm_pkg::A_CTRL0, 32'h00000035);
		wr(motor_pwm_pkg::A_CTRL1, 32'h00000008);
		wr(motor_pwm_pkg::A_LBUF, 32'h00000015);
		wr(motor_pwm_pkg::A_LDSW, 32'h00000008);
		repeat (4) @(posedge clk);
		chk(pins, 6'h2A);
		cmatch <= 1'b1;
		repeat (8) @(posedge clk);
		chk(pins, 6'h15);
		cmatch <= 1'b0;
		wr(motor_pwm_pkg::A_CTRL0, 32'h00000025);
		wr(motor_pwm_pkg::A_LBUF, 32'h0000002A);
		wr(motor_pwm_pkg::A_LDSW, 32'h00000008);
		repeat (4) @(posedge clk);
		chk(pins, 6'h2A);
		wr(motor_pwm_pkg::A_CTRL1, 32'h00000000);
		$display("test switching done");
		close_out();
	end
endmodule

//--- verilog/three_phase_motor_pwm.sv
`timescale 1ns/1ps
module three_phase_motor_pwm #(
	parameter int CW = 16
) (
	// clock and reset
	input  wire logic          CLK_SYS,
	input  wire logic          RSTN,
	// avalon-mm slave
	input  wire logic [5:0]    AVS_ADDRESS,
	input  wire logic          AVS_READ,
	input  wire logic          AVS_WRITE,
	input  wire logic [31:0]   AVS_WRITEDATA,
	input  wire logic [3:0]    AVS_BYTEENABLE,
	output logic      [31:0]   AVS_READDATA,
	output logic               AVS_WAITREQUEST,
	// external pins
	input  wire logic          COMPARE_MATCH,
	input  wire logic          OUTPUT_KILL_PIN,
	output logic               PHASE_U_POS,
	output logic               PHASE_U_NEG,
	output logic               PHASE_V_POS,
	output logic               PHASE_V_NEG,
	output logic               PHASE_W_POS,
	output logic               PHASE_W_NEG,
	// event requests
	output logic               UNDERFLOW_REQ,
	output logic               MATCH_REQ
);
	if (CW < 2 || CW > 16) begin : g_chk
		$error("CW must be 2 to 16");
	end

	// field positions, short local names for the package ones
	localparam int C0_MODE = motor_pwm_pkg::C0_MODE;
	localparam int C0_LDM  = motor_pwm_pkg::C0_LDM;
	localparam int C0_LDU  = motor_pwm_pkg::C0_LDU;
	localparam int C0_SRC  = motor_pwm_pkg::C0_SRC;
	localparam int C0_OEN  = motor_pwm_pkg::C0_OEN;
	localparam int C0_KEN  = motor_pwm_pkg::C0_KEN;
	localparam int C1_CKS  = motor_pwm_pkg::C1_CKS;
	localparam int C1_UPDN = motor_pwm_pkg::C1_UPDN;
	localparam int C1_RUN  = motor_pwm_pkg::C1_RUN;
	localparam int C1_DTS  = motor_pwm_pkg::C1_DTS;
	localparam int IQ_UDF  = motor_pwm_pkg::IQ_UDF;
	localparam int IQ_MAT  = motor_pwm_pkg::IQ_MAT;
	localparam int IQ_UDE  = motor_pwm_pkg::IQ_UDE;
	localparam int IQ_MAE  = motor_pwm_pkg::IQ_MAE;

	typedef struct packed {
		logic [6:0]         c0;
		logic [6:0]         c1;
		logic [CW-1:0]      pbuf;
		logic [CW-1:0]      pact;
		logic [CW-1:0]      cnt;
		logic               dn;
		logic [2:0][CW-1:0] dbuf;
		logic [2:0][CW-1:0] dact;
		logic [7:0]         dtr;
		logic [5:0]         sbuf;
		logic [5:0]         sact;
		logic [5:0]         lbuf;
		logic [5:0]         lact;
		logic [5:0]         pol;
		logic [3:0]         irq;
		logic [2:0]         pre;
		logic [2:0][7:0]    dtc;
		logic [2:0]         dtb;
		logic [5:0]         prev;
		logic [5:0]         pin;
		logic               ack;
		logic [31:0]        rd;
		logic [2:0]         cm;
		logic [1:0]         kl;
		logic               udp;
		logic               mtp;
	} st_type;

	st_type st_r;
	st_type st_nxt;

	function automatic logic tick(input logic [1:0] s, input logic [2:0] p);
		logic t;
		t = 1'b0;
		case (s)
			2'b00: t = 1'b1;
			2'b01: t = p[0];
			2'b10: t = &p[1:0];
			2'b11: t = &p;
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	function automatic logic [CW-1:0] m16(input logic [CW-1:0] o, input logic [31:0] d, input logic [3:0] be);
		logic [15:0] r;
		r = 16'(o);
		if (be[0])
			r[7:0] = d[7:0];
		if (be[1])
			r[15:8] = d[15:8];
		return r[CW-1:0];
	endfunction

	logic req;
	logic wr;
	logic ctick;
	logic dtick;
	logic run;
	logic updn;
	logic ev_m;
	logic ev_u;
	logic dten;
	logic kill;
	logic sw_pat;
	logic ld_all;
	logic [2:0] ld_ph;
	logic [5:0] want;
	logic [5:0] blk;
	logic [7:0] lo8;

	assign req = AVS_READ | AVS_WRITE;
	// one wait state gives the read mux a full cycle
	assign AVS_WAITREQUEST = req & ~st_r.ack;
	assign wr = AVS_WRITE & st_r.ack;
	assign AVS_READDATA = st_r.rd;
	assign {PHASE_W_NEG, PHASE_W_POS, PHASE_V_NEG, PHASE_V_POS, PHASE_U_NEG, PHASE_U_POS} = st_r.pin;
	assign UNDERFLOW_REQ = st_r.udp;
	assign MATCH_REQ = st_r.mtp;

	always_comb begin
		st_nxt = st_r;
		ev_m = 1'b0;
		ev_u = 1'b0;
		ld_ph = 3'h0;
		ld_all = 1'b0;
		sw_pat = 1'b0;
		want = 6'h00;
		blk = 6'h00;
		lo8 = AVS_WRITEDATA[7:0];
		run = st_r.c1[C1_RUN];
		updn = st_r.c1[C1_UPDN];
		ctick = tick(st_r.c1[C1_CKS +: 2], st_r.pre);
		dtick = tick(st_r.c1[C1_DTS +: 2], st_r.pre);
		// second sync stage feeds both the third and the compare match edge detect
		st_nxt.cm = {st_r.cm[1:0], COMPARE_MATCH};
		st_nxt.kl = {st_r.kl[0], OUTPUT_KILL_PIN};
		kill = st_r.kl[1] & st_r.c0[C0_KEN];
		st_nxt.pre = st_r.pre + 3'h1;
		st_nxt.ack = req & ~st_r.ack;

		// period counter
		if (!run) begin
			st_nxt.cnt = st_r.cnt;
		end else if (st_r.pact == '0) begin
			st_nxt.cnt = '0;
			st_nxt.dn = 1'b0;
		end else if (ctick) begin
			if (!updn) begin
				st_nxt.dn = 1'b0;
				if (st_r.cnt == st_r.pact) begin
					st_nxt.cnt = '0;
					ev_m = 1'b1;
				end else begin
					st_nxt.cnt = st_r.cnt + 1'b1;
				end
			end else if (!st_r.dn) begin
				if (st_r.cnt >= st_r.pact) begin
					st_nxt.cnt = st_r.pact - 1'b1;
					st_nxt.dn = 1'b1;
					ev_m = 1'b1;
				end else begin
					st_nxt.cnt = st_r.cnt + 1'b1;
				end
			end else if (st_r.cnt == '0) begin
				st_nxt.dn = 1'b0;
				ev_u = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt - 1'b1;
			end
		end
		if ((ev_m && !updn) || ev_u)
			st_nxt.pact = st_r.pbuf;
		if ((ev_m && st_r.c0[C0_LDM]) || (ev_u && st_r.c0[C0_LDU]))
			ld_all = 1'b1;

		// software load switch and compare match pattern switch
		if (wr && AVS_ADDRESS == motor_pwm_pkg::A_LDSW && AVS_BYTEENABLE[0]) begin
			ld_ph = lo8[2:0];
			sw_pat = lo8[motor_pwm_pkg::LS_PAT] & ~st_r.c0[C0_SRC];
		end
		if (st_r.c0[C0_SRC] && st_r.cm[1] && !st_r.cm[2])
			sw_pat = 1'b1;
		for (int i = 0; i < 3; i++) begin
			if (ld_all || ld_ph[i])
				st_nxt.dact[i] = st_r.dbuf[i];
		end
		if (sw_pat) begin
			st_nxt.sact = st_r.sbuf;
			st_nxt.lact = st_r.lbuf;
		end

		// register writes, buffers copy through while stopped
		if (wr) begin
			case (AVS_ADDRESS)
				motor_pwm_pkg::A_CTRL0:
					if (AVS_BYTEENABLE[0])
						st_nxt.c0 = lo8[6:0];
				motor_pwm_pkg::A_CTRL1:
					if (AVS_BYTEENABLE[0])
						st_nxt.c1 = {lo8[6:5], 1'b0, lo8[3:0]};
				motor_pwm_pkg::A_PBUF: begin
					st_nxt.pbuf = m16(st_r.pbuf, AVS_WRITEDATA, AVS_BYTEENABLE);
					if (!run)
						st_nxt.pact = st_nxt.pbuf;
				end
				motor_pwm_pkg::A_DUTY_U, motor_pwm_pkg::A_DUTY_V, motor_pwm_pkg::A_DUTY_W: begin
					for (int i = 0; i < 3; i++) begin
						if (AVS_ADDRESS[4:2] == 3'(i + 3)) begin
							st_nxt.dbuf[i] = m16(st_r.dbuf[i], AVS_WRITEDATA, AVS_BYTEENABLE);
							if (!run)
								st_nxt.dact[i] = st_nxt.dbuf[i];
						end
					end
				end
				motor_pwm_pkg::A_DTR:
					if (AVS_BYTEENABLE[0])
						st_nxt.dtr = lo8;
				motor_pwm_pkg::A_SBUF:
					if (AVS_BYTEENABLE[0]) begin
						st_nxt.sbuf = lo8[5:0];
						if (!run)
							st_nxt.sact = lo8[5:0];
					end
				motor_pwm_pkg::A_LBUF:
					if (AVS_BYTEENABLE[0]) begin
						st_nxt.lbuf = lo8[5:0];
						if (!run)
							st_nxt.lact = lo8[5:0];
					end
				motor_pwm_pkg::A_POL:
					if (AVS_BYTEENABLE[0])
						st_nxt.pol = lo8[5:0];
				motor_pwm_pkg::A_IRQ:
					if (AVS_BYTEENABLE[0])
						st_nxt.irq = {lo8[3:2], lo8[1:0] & st_r.irq[1:0]};
				default: begin
				end
			endcase
		end
		// hardware set beats a software clear
		if (ev_u)
			st_nxt.irq[IQ_UDF] = 1'b1;
		if (ev_m)
			st_nxt.irq[IQ_MAT] = 1'b1;
		st_nxt.udp = ev_u & st_r.irq[IQ_UDE];
		st_nxt.mtp = ev_m & st_r.irq[IQ_MAE];

		// waveform, dead time and pin drive
		dten = (st_r.c0[C0_MODE +: 2] != motor_pwm_pkg::MODE_BLDC);
		for (int i = 0; i < 3; i++) begin
			want[2*i] = st_r.cnt < st_r.dact[i];
			want[2*i+1] = ~want[2*i];
			for (int k = 0; k < 2; k++) begin
				if (st_r.sact[2*i+k])
					want[2*i+k] = st_r.lact[2*i+k];
			end
			if (dten && want[2*i +: 2] != st_r.prev[2*i +: 2]) begin
				st_nxt.dtb[i] = 1'b1;
				st_nxt.dtc[i] = st_r.dtr;
				blk[2*i +: 2] = 2'b11;
			end else if (st_r.dtb[i]) begin
				blk[2*i +: 2] = 2'b11;
				if (dtick) begin
					if (st_r.dtc[i] == 8'h00)
						st_nxt.dtb[i] = 1'b0;
					else
						st_nxt.dtc[i] = st_r.dtc[i] - 8'h01;
				end
			end
		end
		st_nxt.prev = want;
		for (int j = 0; j < 6; j++) begin
			if (!st_r.c0[C0_OEN] || kill || blk[j])
				st_nxt.pin[j] = ~st_r.pol[j];
			else if (st_r.sact[j])
				st_nxt.pin[j] = st_r.lact[j];
			else
				st_nxt.pin[j] = want[j] ? st_r.pol[j] : ~st_r.pol[j];
		end

		// read data captured in the wait cycle
		st_nxt.rd = 32'h0000_0000;
		case (AVS_ADDRESS)
			motor_pwm_pkg::A_CTRL0: st_nxt.rd[7:0] = {1'b1, st_r.c0};
			motor_pwm_pkg::A_CTRL1: st_nxt.rd[7:0] = {1'b1, st_r.c1[6:5], ~(updn & st_r.dn), st_r.c1[3:0]};
			motor_pwm_pkg::A_PBUF: st_nxt.rd[CW-1:0] = st_r.pbuf;
			motor_pwm_pkg::A_DUTY_U: st_nxt.rd[CW-1:0] = st_r.dbuf[0];
			motor_pwm_pkg::A_DUTY_V: st_nxt.rd[CW-1:0] = st_r.dbuf[1];
			motor_pwm_pkg::A_DUTY_W: st_nxt.rd[CW-1:0] = st_r.dbuf[2];
			motor_pwm_pkg::A_DTR: st_nxt.rd[7:0] = st_r.dtr;
			motor_pwm_pkg::A_SBUF: st_nxt.rd[5:0] = st_r.sbuf;
			motor_pwm_pkg::A_LBUF: st_nxt.rd[5:0] = st_r.lbuf;
			motor_pwm_pkg::A_POL: st_nxt.rd[5:0] = st_r.pol;
			motor_pwm_pkg::A_IRQ: st_nxt.rd[7:0] = {motor_pwm_pkg::FILL_ONES, st_r.irq};
			motor_pwm_pkg::A_LDSW: st_nxt.rd[7:0] = motor_pwm_pkg::LDSW_READ;
			motor_pwm_pkg::A_COUNT: st_nxt.rd[CW-1:0] = st_r.cnt;
			motor_pwm_pkg::A_PACT: st_nxt.rd[CW-1:0] = st_r.pact;
			default: st_nxt.rd = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			st_r <= '0;
			st_r.c0 <= motor_pwm_pkg::CTRL0_RST;
			st_r.c1 <= motor_pwm_pkg::CTRL1_RST;
			st_r.irq <= motor_pwm_pkg::IRQ_RST;
			st_r.dtr <= motor_pwm_pkg::DTR_RST;
			st_r.pol <= motor_pwm_pkg::POL_RST;
			st_r.pin <= ~motor_pwm_pkg::POL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);

	stop_hold_a: assert property (!st_r.c1[C1_RUN] |=> $stable(st_r.cnt))
		else $error("counter moved while stopped");
	zero_period_a: assert property (st_r.c1[C1_RUN] && st_r.pact == '0 |=> st_r.cnt == '0)
		else $error("counter left zero with zero period");
	up_wrap_a: assert property (st_r.c1[C1_RUN] && !st_r.c1[C1_UPDN] && ctick && st_r.pact != '0
		&& st_r.cnt == st_r.pact |=> st_r.cnt == '0 && st_r.pact == $past(st_r.pbuf) && st_r.irq[IQ_MAT])
		else $error("up match did not wrap and reload");
	updn_turn_a: assert property (st_r.c1[C1_RUN] && st_r.c1[C1_UPDN] && ctick && !st_r.dn
		&& st_r.pact != '0 && st_r.cnt == st_r.pact |=> st_r.dn && st_r.cnt == $past(st_r.pact) - 1'b1)
		else $error("up-down counter did not turn at top");
	per_copy_a: assert property (wr && AVS_ADDRESS == motor_pwm_pkg::A_PBUF && !st_r.c1[C1_RUN]
		|=> st_r.pact == st_r.pbuf)
		else $error("stopped period write not copied");
	duty_copy_a: assert property (wr && AVS_ADDRESS == motor_pwm_pkg::A_DUTY_V && !st_r.c1[C1_RUN]
		|=> st_r.dact[1] == st_r.dbuf[1])
		else $error("stopped duty write not copied");
	flag_stick_a: assert property (st_r.irq[IQ_UDF] && !(wr && AVS_ADDRESS == motor_pwm_pkg::A_IRQ)
		|=> st_r.irq[IQ_UDF])
		else $error("underflow flag dropped without clear");
	out_gate_a: assert property (!st_r.c0[C0_OEN] |=> st_r.pin == ~$past(st_r.pol))
		else $error("outputs not idle while disabled");
	kill_pin_a: assert property (kill |=> st_r.pin == ~$past(st_r.pol))
		else $error("kill pin did not idle outputs");
	no_overlap_a: assert property (st_r.dtb[0] |=> st_r.pin[1:0] == ~$past(st_r.pol[1:0]))
		else $error("phase pair driven during dead time");
	mode2_nodt_a: assert property (st_r.c0[1:0] == 2'b01 && st_r.dtb == 3'h0 |=> st_r.dtb == 3'h0)
		else $error("dead time started in mode 2");
	dt_len_a: assert property (st_r.c1[6:5] == 2'b00 && st_r.dtb[0] && st_r.dtc[0] == 8'h00
		&& want[1:0] == st_r.prev[1:0] |=> !st_r.dtb[0])
		else $error("dead time overran its reload");
	duty_load_a: assert property (ev_m && st_r.c0[C0_LDM] |=> st_r.dact == $past(st_r.dbuf))
		else $error("duty not loaded on period match");

	updn_top_c: cover property (st_r.c1[C1_UPDN] && ev_m);
	underflow_c: cover property (ev_u ##1 st_r.irq[IQ_UDF]);
	dead_time_c: cover property (!st_r.dtb[0] ##1 st_r.dtb[0]);
	pattern_c: cover property (sw_pat && st_r.c0[C0_SRC]);
endmodule
